// >>> hw/i2c_seq_defs.vh
// constants for the two-wire master sequencer
// assumes a 20 MHz reference clock
`ifndef I2C_SEQ_DEFS_VH
`define I2C_SEQ_DEFS_VH
`define I2C_FIFO_WIDTH    8
`define I2C_FIFO_DEPTH    16
`define I2C_FIFO_AW       4
`define I2C_RSV_HS_PFX    4'h1
`define I2C_RSV_TEN_PFX   5'h1e
`define I2C_RSV_FUTURE    5'h1f
`define I2C_RSV_ZERO_PFX  4'h0
`endif

// >>> hw/i2c_tx_fifo.v
// flip-flop FIFO with valid/ready on both sides and a synchronous flush
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
module i2c_tx_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             ref_clk,
    input  wire             nrst,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [AW:0]      level
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wr_ff;
    reg [AW-1:0]    rd_ff;
    reg [AW:0]      cnt_ff;
    wire            push = in_valid && in_ready;
    wire            pop  = out_valid && out_ready;
    // full when the count reaches 2**AW, which is DEPTH
    assign in_ready  = !cnt_ff[AW];
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign out_data  = mem_ff[rd_ff];
    assign level     = cnt_ff;
    always @(posedge ref_clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ff  <= {AW{1'b0}};
            rd_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ff  <= {AW{1'b0}};
            rd_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) wr_ff <= wr_ff + 1'b1;
            if (pop)  rd_ff <= rd_ff + 1'b1;
            cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // i2c_tx_fifo
`default_nettype wire

// >>> hw/i2c_master_sequencer.v
// master sequencer of a two-wire serial bus: START/RESTART/STOP, address
// bytes, byte transfers from a transmit FIFO, arbitration and bus-free wait
// assumes scl_in/sda_in come straight from pins; control bits are plain ports
// Overview of operation
// (RULE_01) address byte follows every START
// (RULE_02) seven-bit mode: one FIFO byte address
// (RULE_03) reserved address patterns are flagged
// (RULE_04) ten-bit: prefix then low byte, software-queued
// (RULE_05) start waits for a free bus
// (RULE_06) restart deferred, self-clears as it begins
// (RULE_07) start clears after STOP is driven
// (RULE_08) stop request generates STOP
// (RULE_09) start plus restart: START, later RESTART
// (RULE_10) restart plus stop: RESTART, both cleared
// (RULE_11) all three: stop cleared and ignored
// (RULE_12) master disabled forces requests to zero
// (RULE_13) software changes config only when idle
// (RULE_14) read: address acknowledged sets flag
// (RULE_15) receive acks until count, then NACK
// (RULE_16) software may prefill FIFO before start
// (RULE_17) empty FIFO stalls at byte start
// (RULE_18) FIFO drained: done, then RESTART or STOP
// (RULE_19) compare driven and sensed SDA per bit
// (RULE_20) lost arbitration: release, flags, flush, clear
// (RULE_21) own address after loss: become target
// (RULE_22) software clears lockout, reloads FIFO
// (RULE_23) busy bus: wait STOP plus low time
// (RULE_24) SCL low is (count+1) clock periods; the code drives it low count+2 periods or more
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_defs.vh"
module i2c_master_sequencer (
    input  wire       ref_clk,
    input  wire       nrst,
    input  wire       master_enable,
    input  wire       start_set,
    input  wire       restart_set,
    input  wire       stop_set,
    input  wire       ten_bit_address_select,
    input  wire       scl_push_pull_select,
    input  wire       high_speed_select,
    input  wire [7:0] scl_low_count,
    input  wire [7:0] scl_high_count,
    input  wire [7:0] rx_count,
    input  wire [6:0] own_address,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    output wire       tx_ready,
    input  wire       flag_clear,
    input  wire       lockout_clear,
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        scl_out,
    output reg        scl_oe,
    output reg        sda_out,
    output reg        sda_oe,
    output reg        start_ff,
    output reg        restart_ff,
    output reg        stop_ff,
    output reg        arbitration_lost_flag,
    output reg        tx_lockout_ff,
    output reg        addr_ack_ff,
    output reg        done_ff,
    output reg        nack_ff,
    output reg        reserved_addr_ff,
    output reg        target_mode_ff,
    output reg        bus_busy_ff,
    output reg [7:0]  rx_data_ff,
    output reg        rx_strobe_ff
);
    localparam [8:0] S_IDLE  = 9'h001, S_WAIT  = 9'h002, S_START = 9'h004,
                     S_BIT   = 9'h008, S_ACK   = 9'h010, S_NEXT  = 9'h020,
                     S_RSTRT = 9'h040, S_STOP  = 9'h080, S_LOST  = 9'h100;

    // two-flop synchronisers; the first stage feeds only the second
    reg scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff, scl_d_ff, sda_d_ff;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            scl_m_ff <= 1'b1; scl_s_ff <= 1'b1; scl_d_ff <= 1'b1;
            sda_m_ff <= 1'b1; sda_s_ff <= 1'b1; sda_d_ff <= 1'b1;
        end else begin
            scl_m_ff <= scl_in; scl_s_ff <= scl_m_ff; scl_d_ff <= scl_s_ff;
            sda_m_ff <= sda_in; sda_s_ff <= sda_m_ff; sda_d_ff <= sda_s_ff;
        end
    end
    wire start_cond = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
    wire stop_cond  = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;
    wire scl_rise   = scl_s_ff && !scl_d_ff;

    // reserved code check on the upper seven bits of an address byte
    function is_reserved;
        input [6:0] a;
        begin
            is_reserved = (a[6:3] == `I2C_RSV_ZERO_PFX) || (a[6:3] == `I2C_RSV_HS_PFX) ||
                          (a[6:2] == `I2C_RSV_TEN_PFX) || (a[6:2] == `I2C_RSV_FUTURE);
        end
    endfunction

    reg        pop_ff;
    wire [7:0] fifo_data;
    wire       fifo_valid;
    wire [`I2C_FIFO_AW:0] fifo_level;
    reg        flush_ff;
    i2c_tx_fifo #(
        .WIDTH (`I2C_FIFO_WIDTH),
        .DEPTH (`I2C_FIFO_DEPTH),
        .AW    (`I2C_FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .flush     (flush_ff),
        .in_data   (tx_data),
        .in_valid  (tx_valid && !tx_lockout_ff),
        .in_ready  (tx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop_ff),
        .level     (fifo_level)
    );

    reg [8:0] st_ff;
    reg [7:0] tim_ff;          // scl phase timer
    reg [1:0] ph_ff;           // 0 low,1/2/3 high sub-phases
    reg [2:0] bit_ff;
    reg [7:0] sh_ff;
    reg [7:0] cnt_ff;          // bytes still to receive
    reg       addr_ph_ff;      // current byte is an address byte
    reg       rd_ff;           // read direction latched from address
    reg       ten_sec_ff;      // second ten-bit address byte follows
    reg       snoop_ok_ff;     // own address still matches while snooping
    reg [3:0] snoop_cnt_ff;

    wire low_done  = (tim_ff == scl_low_count);   // [RULE_24]
    wire high_done = (tim_ff == scl_high_count);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= S_IDLE; tim_ff <= 8'h00; ph_ff <= 2'h0; bit_ff <= 3'h0;
            sh_ff <= 8'h00; cnt_ff <= 8'h00; addr_ph_ff <= 1'b0; rd_ff <= 1'b0;
            ten_sec_ff <= 1'b0; pop_ff <= 1'b0; flush_ff <= 1'b0;
            scl_out <= 1'b1; scl_oe <= 1'b0; sda_out <= 1'b0; sda_oe <= 1'b0;
            start_ff <= 1'b0; restart_ff <= 1'b0; stop_ff <= 1'b0;
            arbitration_lost_flag <= 1'b0; tx_lockout_ff <= 1'b0;
            addr_ack_ff <= 1'b0; done_ff <= 1'b0; nack_ff <= 1'b0;
            reserved_addr_ff <= 1'b0; target_mode_ff <= 1'b0; bus_busy_ff <= 1'b0;
            rx_data_ff <= 8'h00; rx_strobe_ff <= 1'b0;
            snoop_ok_ff <= 1'b0; snoop_cnt_ff <= 4'h0;
        end else begin
            pop_ff <= 1'b0;
            flush_ff <= 1'b0;
            rx_strobe_ff <= 1'b0;
            // software clears; hardware sets below win in the same cycle
            if (flag_clear) begin
                arbitration_lost_flag <= 1'b0; addr_ack_ff <= 1'b0;
                done_ff <= 1'b0; nack_ff <= 1'b0; reserved_addr_ff <= 1'b0;
                target_mode_ff <= 1'b0;
            end
            if (lockout_clear) tx_lockout_ff <= 1'b0;  // [RULE_22]
            if (start_set)   start_ff   <= 1'b1;
            if (restart_set) restart_ff <= 1'b1;
            if (stop_set)    stop_ff    <= 1'b1;
            if (start_cond) bus_busy_ff <= 1'b1;
            else if (stop_cond) bus_busy_ff <= 1'b0;
            tim_ff <= tim_ff + 8'h01;
            // drive SCL actively high only in push-pull mode
            scl_out <= 1'b0;
            case (st_ff)
                S_IDLE: begin
                    scl_oe <= 1'b0; sda_oe <= 1'b0;
                    tim_ff <= 8'h00;
                    if (start_ff && master_enable && !start_cond) begin
                        st_ff <= S_WAIT;               // [RULE_05]
                    end
                end
                S_WAIT: begin
                    // bus must stay idle for one low period before START
                    if (bus_busy_ff || !scl_s_ff || !sda_s_ff || start_cond) begin
                        tim_ff <= 8'h00;               // [RULE_23]
                    end else if (low_done && fifo_valid) begin
                        st_ff <= S_START; tim_ff <= 8'h00;
                    end
                end
                S_START, S_RSTRT: begin
                    // restart: full low phase, SCL high with SDA free, then as START
                    scl_oe <= scl_push_pull_select;
                    scl_out <= 1'b1;
                    if (st_ff == S_RSTRT && ph_ff == 2'h0) begin
                        scl_oe <= 1'b1; scl_out <= 1'b0; sda_oe <= 1'b0;
                        if (low_done) begin ph_ff <= 2'h3; tim_ff <= 8'h00; end
                    end else if (st_ff == S_RSTRT && ph_ff == 2'h3) begin
                        sda_oe <= 1'b0;
                        if (high_done) begin ph_ff <= 2'h1; tim_ff <= 8'h00; end
                    end else begin
                        if (st_ff == S_RSTRT) restart_ff <= 1'b0; // [RULE_06]
                        sda_oe <= 1'b1; sda_out <= 1'b0;
                        if (high_done) begin
                            st_ff <= S_NEXT; tim_ff <= 8'h00; ph_ff <= 2'h0;
                            scl_oe <= 1'b1; scl_out <= 1'b0;
                            addr_ph_ff <= 1'b1;        // [RULE_01]
                            ten_sec_ff <= ten_bit_address_select;  // [RULE_04]
                        end
                    end
                end
                S_NEXT: begin
                    // byte boundary with SCL low
                    scl_oe <= 1'b1;
                    if (addr_ph_ff || !rd_ff) begin
                        if (fifo_valid) begin
                            sh_ff <= fifo_data; pop_ff <= 1'b1; // [RULE_02]
                            if (addr_ph_ff && !ten_sec_ff) begin
                                rd_ff <= fifo_data[0];
                                reserved_addr_ff <= is_reserved(fifo_data[7:1]) |
                                                    reserved_addr_ff; // [RULE_03]
                            end
                            bit_ff <= 3'h7; ph_ff <= 2'h0; tim_ff <= 8'h00;
                            st_ff <= S_BIT;
                        end else if (restart_ff) begin
                            done_ff <= 1'b1;           // [RULE_18]
                            st_ff <= S_RSTRT; ph_ff <= 2'h0; tim_ff <= 8'h00; // [RULE_10]
                            stop_ff <= 1'b0;
                        end else if (stop_ff) begin
                            done_ff <= 1'b1;
                            st_ff <= S_STOP; ph_ff <= 2'h0; tim_ff <= 8'h00; // [RULE_08]
                        end
                        // otherwise hold SCL low and wait for data [RULE_17]
                    end else begin
                        bit_ff <= 3'h7; ph_ff <= 2'h0; tim_ff <= 8'h00;
                        st_ff <= S_BIT;
                    end
                end
                S_BIT: begin
                    if (ph_ff == 2'h0) begin
                        scl_oe <= 1'b1;
                        sda_oe <= (rd_ff && !addr_ph_ff) ? 1'b0 : !sh_ff[bit_ff];
                        sda_out <= 1'b0;
                        if (low_done) begin ph_ff <= 2'h2; tim_ff <= 8'h00; end
                    end else begin
                        scl_oe <= scl_push_pull_select;
                        scl_out <= 1'b1;
                        if (!scl_s_ff) tim_ff <= 8'h00;  // clock stretch/synchronise
                        if (scl_rise && !(rd_ff && !addr_ph_ff) && sh_ff[bit_ff] && !sda_s_ff) begin
                            st_ff <= S_LOST;           // [RULE_19]
                        end else if (scl_rise && rd_ff && !addr_ph_ff) begin
                            rx_data_ff <= {rx_data_ff[6:0], sda_s_ff};
                        end
                        if (high_done && scl_s_ff) begin
                            tim_ff <= 8'h00; ph_ff <= 2'h0;
                            scl_oe <= 1'b1; scl_out <= 1'b0;
                            if (bit_ff == 3'h0) st_ff <= S_ACK;
                            else bit_ff <= bit_ff - 3'h1;
                        end
                    end
                end
                S_ACK: begin
                    if (ph_ff == 2'h0) begin
                        scl_oe <= 1'b1;
                        // receiving: ack until count reached, nack the last [RULE_15]
                        sda_oe <= rd_ff && !addr_ph_ff && (cnt_ff != 8'h01);
                        sda_out <= 1'b0;
                        if (low_done) begin ph_ff <= 2'h2; tim_ff <= 8'h00; end
                    end else begin
                        scl_oe <= scl_push_pull_select;
                        scl_out <= 1'b1;
                        if (!scl_s_ff) tim_ff <= 8'h00;
                        if (high_done && scl_s_ff) begin
                            tim_ff <= 8'h00; ph_ff <= 2'h0;
                            scl_oe <= 1'b1; scl_out <= 1'b0; sda_oe <= 1'b0;
                            st_ff <= S_NEXT;
                            if (rd_ff && !addr_ph_ff) begin
                                rx_strobe_ff <= 1'b1;
                                cnt_ff <= cnt_ff - 8'h01;
                                if (cnt_ff == 8'h01) begin
                                    done_ff <= 1'b1;
                                    if (restart_ff) begin
                                        st_ff <= S_RSTRT; stop_ff <= 1'b0;
                                    end else begin
                                        st_ff <= S_STOP;
                                    end
                                end
                            end else if (sda_s_ff) begin
                                nack_ff <= 1'b1;
                                st_ff <= S_STOP;
                            end else begin
                                if (addr_ph_ff && !ten_sec_ff) begin
                                    addr_ack_ff <= 1'b1;    // [RULE_14]
                                    addr_ph_ff <= 1'b0;
                                    cnt_ff <= rx_count;
                                end
                                ten_sec_ff <= 1'b0;
                            end
                        end
                    end
                end
                S_STOP: begin
                    // SDA low, release SCL, then release SDA
                    sda_oe <= (ph_ff != 2'h2);
                    sda_out <= 1'b0;
                    scl_oe <= (ph_ff == 2'h0) ? 1'b1 : scl_push_pull_select;
                    scl_out <= (ph_ff != 2'h0);
                    if (ph_ff == 2'h0 && low_done) begin ph_ff <= 2'h1; tim_ff <= 8'h00; end
                    if (ph_ff == 2'h1 && high_done) begin ph_ff <= 2'h2; tim_ff <= 8'h00; end
                    if (ph_ff == 2'h2 && high_done) begin
                        ph_ff <= 2'h0; st_ff <= S_IDLE;
                        start_ff <= 1'b0; stop_ff <= 1'b0;   // [RULE_07]
                    end
                end
                S_LOST: begin
                    scl_oe <= 1'b0; sda_oe <= 1'b0;      // [RULE_20]
                    arbitration_lost_flag <= 1'b1;
                    tx_lockout_ff <= 1'b1; flush_ff <= 1'b1;
                    start_ff <= 1'b0; restart_ff <= 1'b0; stop_ff <= 1'b0;
                    ph_ff <= 2'h0;
                    st_ff <= S_IDLE;
                end
                default: st_ff <= S_IDLE;
            endcase
            // start and restart together: the restart waits in restart_ff [RULE_09] [RULE_11]
            if (start_ff && restart_ff && stop_ff && st_ff == S_START) stop_ff <= 1'b0;
            if (!master_enable) begin
                start_ff <= 1'b0; restart_ff <= 1'b0; stop_ff <= 1'b0;  // [RULE_12]
            end
            // watch other masters' address bytes for our own address
            if (start_cond) begin
                snoop_cnt_ff <= 4'h0; snoop_ok_ff <= 1'b1;
            end else if (scl_rise && snoop_cnt_ff < 4'h8) begin
                snoop_cnt_ff <= snoop_cnt_ff + 4'h1;
                if (snoop_cnt_ff < 4'h7 && sda_s_ff != own_address[3'h6 - snoop_cnt_ff[2:0]])
                    snoop_ok_ff <= 1'b0;
                if (snoop_cnt_ff == 4'h7 && snoop_ok_ff && st_ff != S_BIT && st_ff != S_ACK &&
                    arbitration_lost_flag) begin
                    target_mode_ff <= 1'b1;       // [RULE_21]
                end
            end
        end
    end
endmodule // i2c_master_sequencer
`default_nettype wire

// >>> dv/i2c_seq_props.sv
// checker: port-level timing of the master sequencer
// assumes one ref_clk domain, nrst active low, pins fed back on scl_in/sda_in
`timescale 1ns/1ps
`default_nettype none
module i2c_seq_props (
    input wire logic       ref_clk, nrst, master_enable,
    input wire logic [7:0] scl_low_count,
    input wire logic       scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe,
    input wire logic       start_ff, restart_ff, stop_ff, arbitration_lost_flag,
    input wire logic       tx_lockout_ff, addr_ack_ff, done_ff, bus_busy_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [8:0] idle_ff;
    logic [8:0] low_ff;
    wire        scl_low = scl_oe & ~scl_out;
    wire        sda_low = sda_oe & ~sda_out;
    // idle count on raw pins runs ahead of the synced view, so it is a safe upper bound
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idle_ff <= 9'h000;
            low_ff  <= 9'h000;
        end else begin
            idle_ff <= !(scl_in && sda_in) ? 9'h000 : idle_ff + {8'h00, idle_ff != 9'h1ff};
            low_ff  <= !scl_low ? 9'h000 : low_ff + {8'h00, low_ff != 9'h1ff};
        end
    end
    sequence stop_seq;
        (!scl_low && sda_low) ##1 (!scl_low && !sda_oe);
    endsequence
    sequence rstart_seq;
        (!scl_low && !sda_oe) ##1 (!scl_low && sda_low);
    endsequence
    req_clear_a: assert property (!master_enable |-> ##1 !(start_ff | restart_ff | stop_ff))
        else $error("request bit survived master disable");
    arb_release_a: assert property ($rose(arbitration_lost_flag) |-> ##[0:2]
        (!scl_oe && !sda_oe && tx_lockout_ff && !start_ff && !restart_ff && !stop_ff))
        else $error("lost arbitration without release, lockout and clear");
    start_clear_a: assert property ($fell(start_ff) && master_enable && !arbitration_lost_flag
        |-> !sda_oe && !scl_low) else $error("start cleared before bus released");
    restart_drop_a: assert property ($fell(restart_ff) && master_enable && !arbitration_lost_flag
        |-> ##[0:1] (sda_low && !scl_low && !stop_ff)) else $error("restart cleared off its condition");
    bus_free_a: assert property ($rose(sda_low) && !bus_busy_ff |-> idle_ff > {1'b0, scl_low_count})
        else $error("start issued without bus free time");
    scl_low_a: assert property ($fell(scl_low) |-> low_ff > {1'b0, scl_low_count})
        else $error("scl low phase too short");
    done_cond_a: assert property ($rose(done_ff) |-> ##[0:300] (stop_seq or rstart_seq))
        else $error("no stop or restart after done");
    addr_ack_a: assert property ($rose(addr_ack_ff) |-> start_ff && !arbitration_lost_flag)
        else $error("address ack outside own transfer");
endmodule // i2c_seq_props
bind i2c_master_sequencer i2c_seq_props i2c_seq_props_i (.*);
`default_nettype wire

// >>> dv/i2c_target_model.sv
// model: target that acks address and writes, returns a fixed read byte
// assumes scl/sda are the resolved wire levels with pull-ups
`timescale 1ns/1ps
`default_nettype none
module i2c_target_model #(
    parameter logic [6:0] ADDR = 7'h55,
    parameter logic [7:0] RDB  = 8'h96
) (
    input  wire logic scl,
    input  wire logic sda,
    output var  logic sda_pull
);
    logic       on = 1'b0, first = 1'b0, rd = 1'b0;
    logic [7:0] sh = 8'h00;
    int         cnt = 0;
    initial sda_pull = 1'b0;
    always @(negedge sda) if (scl === 1'b1) begin
        on = 1'b1;
        first = 1'b1;
        cnt = 0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        on = 1'b0;
        sda_pull = 1'b0;
    end
    always @(posedge scl) if (on) begin
        // master nack ends a read; let go so the stop can form
        if (cnt == 8 && rd && !first && sda) on = 1'b0;
        if (cnt < 8) sh = {sh[6:0], sda};
        cnt = cnt + 1;
    end
    always @(negedge scl) if (on) begin
        sda_pull = 1'b0;
        if (cnt == 9) begin
            cnt = 0;
            first = 1'b0;
        end
        if (cnt == 8 && first) begin
            rd = sh[0];
            on = (sh[7:1] == ADDR) || (sh[7:3] == 5'h1e);
            sda_pull = on;
        end else if (cnt == 8) sda_pull = !rd;
        else if (rd && !first) sda_pull = !RDB[7 - cnt];
    end
endmodule // i2c_target_model
`default_nettype wire

// >>> dv/i2c_master_sequencer_tb_top.sv
// bench: drives control ports and fifo, scores the resolved bus
// assumes a target model and a rival master on sda
`timescale 1ns/1ps
`default_nettype none
`define chk(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
`define waitfor(c) begin n = 0; while (!(c) && n < 6000) begin @(posedge ref_clk); n++; end if (!(c)) begin errors++; tally_and_finish; end end
module i2c_master_sequencer_tb_top;
    localparam logic [6:0] ADDR = 7'h55;
    localparam logic [7:0] RDB  = 8'h96;
    localparam logic [9:0] EV_S = 10'h200;
    localparam logic [9:0] EV_P = 10'h201;
    logic ref_clk = 0, nrst = 0, master_enable = 0, start_set = 0, restart_set = 0, stop_set = 0;
    logic ten_bit_address_select = 0, tx_valid = 0, flag_clear = 0, lockout_clear = 0, rival_sda = 0;
    logic [7:0] scl_low_count = 8'h03, scl_high_count = 8'h03, rx_count = 8'h01, tx_data = 8'h00;
    wire  tx_ready, scl_out, scl_oe, sda_out, sda_oe, start_ff, restart_ff, stop_ff, tgt_pull;
    wire  arbitration_lost_flag, tx_lockout_ff, addr_ack_ff, done_ff, bus_busy_ff, rx_strobe_ff;
    wire  [7:0] rx_data_ff;
    int   errors = 0, total_checks = 0, n = 0, seed = 82, bits = 0, k;
    logic [9:0] expq[$];
    logic [9:0] sh = 10'h000;
    wire  scl_in = ~(scl_oe & ~scl_out);
    wire  sda_in = ~((sda_oe & ~sda_out) | tgt_pull | rival_sda);
    always #25 ref_clk = ~ref_clk;
    i2c_master_sequencer i2c_master_sequencer_i (.*, .scl_push_pull_select(1'b0),
        .high_speed_select(1'b0), .own_address(7'h3c), .nack_ff(), .reserved_addr_ff(),
        .target_mode_ff());
    i2c_target_model #(.ADDR(ADDR), .RDB(RDB)) i2c_target_model_i (.scl(scl_in), .sda(sda_in),
        .sda_pull(tgt_pull));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic note(input logic [9:0] v);
        logic [9:0] e;
        e = (expq.size() != 0) ? expq.pop_front() : 10'h3ff;
        `chk(v, e)
    endtask
    // bus watcher: start/stop and each byte plus ack
    always @(sda_in) if (nrst && scl_in === 1'b1) begin
        bits = 0;
        note(sda_in ? EV_P : EV_S);
    end
    always @(posedge scl_in) if (nrst) begin
        sh = {sh[8:0], sda_in};
        bits++;
        if (bits == 9) begin
            bits = 0;
            note({1'b0, sh[8:0]});
        end
    end
    always @(posedge ref_clk) if (rx_strobe_ff === 1'b1) `chk(rx_data_ff, RDB)
    task automatic send(input logic [7:0] q[$], input bit ex);
        foreach (q[j]) begin
            tx_data <= q[j];
            tx_valid <= 1'b1;
            if (ex) expq.push_back({1'b0, q[j], 1'b0});
            @(posedge ref_clk);
            `waitfor(tx_ready === 1'b1)
        end
        tx_valid <= 1'b0;
    endtask
    task automatic pulse3(input logic s, r, p);
        start_set <= s;
        restart_set <= r;
        stop_set <= p;
        @(posedge ref_clk);
        {start_set, restart_set, stop_set} <= 3'b000;
    endtask
    task automatic finish;
        @(posedge ref_clk);
        `waitfor(start_ff === 1'b0)
        `chk({done_ff, addr_ack_ff}, 2'b11)
        flag_clear <= 1'b1;
        @(posedge ref_clk);
        flag_clear <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        pulse3(1'b1, 1'b1, 1'b1);
        @(posedge ref_clk);
        `chk({start_ff, restart_ff, stop_ff}, 3'b000)
        master_enable <= 1'b1;
        // write, then start+restart+stop, stop ignored
        expq.push_back(EV_S);
        send('{{ADDR, 1'b0}, 8'($random(seed)), 8'($random(seed))}, 1);
        expq.push_back(EV_P);
        pulse3(1'b1, 1'b0, 1'b1);
        finish();
        expq.push_back(EV_S);
        send('{{ADDR, 1'b0}, 8'($random(seed))}, 1);
        expq.push_back(EV_S);
        pulse3(1'b1, 1'b1, 1'b1);
        @(posedge ref_clk);
        `waitfor(restart_ff === 1'b0)
        send('{{ADDR, 1'b0}, 8'($random(seed))}, 1);
        expq.push_back(EV_P);
        pulse3(1'b0, 1'b0, 1'b1);
        finish();
        // read of a random count, last byte nacked
        k = {$random(seed)} % 3 + 1;
        rx_count <= 8'(k);
        expq.push_back(EV_S);
        send('{{ADDR, 1'b1}}, 1);
        for (int i = 0; i < k; i++) expq.push_back({1'b0, RDB, i == k - 1});
        expq.push_back(EV_P);
        pulse3(1'b1, 1'b0, 1'b1);
        finish();
        // ten-bit: prefix then low byte, software queued
        ten_bit_address_select <= 1'b1;
        expq.push_back(EV_S);
        send('{8'hf2, 8'h34, 8'($random(seed))}, 1);
        expq.push_back(EV_P);
        pulse3(1'b1, 1'b0, 1'b1);
        finish();
        ten_bit_address_select <= 1'b0;
        // rival holds the bus: start waits for its stop
        expq.push_back(EV_S);
        expq.push_back(EV_P);
        expq.push_back(EV_S);
        rival_sda <= 1'b1;
        send('{{ADDR, 1'b0}}, 1);
        pulse3(1'b1, 1'b0, 1'b1);
        repeat (40) @(posedge ref_clk);
        `chk({sda_oe, bus_busy_ff}, 2'b01)
        expq.push_back(EV_P);
        rival_sda <= 1'b0;
        finish();
        // rival pulls sda on our first address bit, a one
        expq.push_back(EV_S);
        expq.push_back(EV_P);
        send('{{ADDR, 1'b0}}, 0);
        pulse3(1'b1, 1'b0, 1'b1);
        `waitfor(scl_in === 1'b0)
        rival_sda <= 1'b1;
        `waitfor(arbitration_lost_flag === 1'b1)
        @(posedge ref_clk);
        `chk({tx_lockout_ff, start_ff, restart_ff, stop_ff, scl_oe}, 5'b10000)
        rival_sda <= 1'b0;
        repeat (20) @(posedge ref_clk);
        {lockout_clear, flag_clear} <= 2'b11;
        @(posedge ref_clk);
        {lockout_clear, flag_clear} <= 2'b00;
        @(posedge ref_clk);
        `chk({tx_lockout_ff, arbitration_lost_flag}, 2'b00)
        `chk(expq.size() == 0, 1'b1)
        tally_and_finish();
    end
endmodule // i2c_master_sequencer_tb_top
`default_nettype wire
